/* File: sim/lbac_cmd_handler_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module lbac_cmd_handler_tb import lbac_pkg::*;;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] len_lo;
		logic [7:0] term;
		logic bad_sum;
		logic [3:0] lc;
		logic [1:0] auth;
		logic ferr;
		logic stall;
		logic [7:0] rcode;
		logic [7:0] scode;
	} lbac_row_t;

	// cmd len_lo term badsum lc auth ferr stall rcode scode
	localparam lbac_row_t ROWS [14] = '{
		'{8'h4b, 8'h01, 8'h03, 1'b0, 4'h1, 2'h2, 1'b0, 1'b0, 8'h4b, 8'h00},
		'{8'h4b, 8'h01, 8'h00, 1'b1, 4'h0, 2'h0, 1'b0, 1'b1, 8'hcb, 8'hc1},
		'{8'h4b, 8'h01, 8'h03, 1'b1, 4'h0, 2'h0, 1'b0, 1'b0, 8'hcb, 8'hc2},
		'{8'h4b, 8'h02, 8'h03, 1'b0, 4'h0, 2'h0, 1'b0, 1'b0, 8'hcb, 8'hc1},
		'{8'h4b, 8'h01, 8'h03, 1'b0, 4'h0, 2'h0, 1'b0, 1'b0, 8'hcb, 8'hc3},
		'{8'h4b, 8'h01, 8'h03, 1'b0, 4'h1, 2'h1, 1'b0, 1'b0, 8'hcb, 8'hc4},
		'{8'h4b, 8'h01, 8'h03, 1'b0, 4'h2, 2'h0, 1'b0, 1'b1, 8'hcb, 8'hc4},
		'{8'h4c, 8'h05, 8'h03, 1'b0, 4'h1, 2'h2, 1'b0, 1'b1, 8'h4c, 8'h00},
		'{8'h4c, 8'h05, 8'h03, 1'b0, 4'h3, 2'h3, 1'b1, 1'b0, 8'hcc, 8'hc5},
		'{8'h4c, 8'h05, 8'h03, 1'b0, 4'h1, 2'h0, 1'b0, 1'b0, 8'hcc, 8'hc4},
		'{8'h4c, 8'h04, 8'h03, 1'b0, 4'h1, 2'h2, 1'b0, 1'b0, 8'hcc, 8'hc1},
		'{8'h4c, 8'h05, 8'h00, 1'b0, 4'h1, 2'h2, 1'b0, 1'b0, 8'hcc, 8'hc1},
		'{8'h4c, 8'h05, 8'h03, 1'b1, 4'h1, 2'h2, 1'b0, 1'b0, 8'hcc, 8'hc2},
		'{8'h4b, 8'h01, 8'h03, 1'b0, 4'hf, 2'h3, 1'b0, 1'b1, 8'h4b, 8'h00}
	};
	localparam logic [31:0] FSTAT = 32'h1234_5678;
	localparam logic [31:0] FADDR = 32'h0040_0c00;

	logic clk = 1'b0, rst_n = 1'b0, rx_valid, rx_ready, tx_valid, tx_ready, stall = 1'b0;
	logic [7:0] rx_data, tx_data;
	logic [3:0] lc = 4'h1;
	logic [1:0] auth = 2'h2;
	logic [8*LOCK_BYTES-1:0] lock;
	logic flash_req, fdone = 1'b0, ferr = 1'b0;
	logic [31:0] arc_cfg;
	int fwait = 0, fcount = 0, cycles = 0, fail_count = 0, compares = 0;

	always #5 clk = ~clk;

	initial begin
		for (int i = 0; i < LOCK_BYTES; i++)
			lock[8*i+:8] = 8'(8'h11 * i);
	end

	lbac_cmd_handler lbac_cmd_handler_i (.clk(clk), .rst_n(rst_n), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data_reg(tx_data),
		.tx_valid_reg(tx_valid), .tx_ready(tx_ready), .lifecycle_state(lc),
		.auth_level(auth), .lock_data(lock), .flash_wr_req_reg(flash_req),
		.rollback_config_reg(arc_cfg), .flash_wr_done(fdone), .flash_wr_error(ferr),
		.flash_status(FSTAT), .flash_fail_addr(FADDR));

	lbac_host lbac_host_i (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .stall(stall));

	// Flash side answers three cycles after each request
	always @(posedge clk) begin
		fdone <= 1'b0;
		if (flash_req) begin
			fwait <= 3;
			fcount++;
		end else if (fwait != 0) begin
			fwait <= fwait - 1;
			if (fwait == 1)
				fdone <= 1'b1;
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end

	task automatic conclude();
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic run_row(input lbac_row_t r, input int idx);
		logic [7:0] f[$], e[$], p[$];
		logic [7:0] s, b;
		logic [31:0] det, adr;
		int n, fc0, fexp;
		s = r.len_lo;
		// Noise ahead of the start byte must be dropped
		f = '{8'h55, RESP_START_BYTE, CMD_START_BYTE, 8'h00, r.len_lo, r.cmd};
		s += r.cmd;
		for (int k = 1; k < r.len_lo; k++) begin
			b = 8'(8'ha0 + 8 * idx + k);
			f.push_back(b);
			p.push_back(b);
			s += b;
		end
		f.push_back(8'(8'h00 - s + r.bad_sum));
		f.push_back(r.term);
		e = '{8'h00};
		if (r.cmd == CMD_LOCK_REQ && r.rcode == RESP_LOCK_DATA) begin
			e.push_back(LEN_LOCK_DATA);
			e.push_back(RESP_LOCK_DATA);
			for (int i = 0; i < LOCK_BYTES; i++)
				e.push_back(lock[8*i+:8] | ((i == LOCK_BYTES - 1) ? HASH_LOCK_MASK : 8'h00));
		end else begin
			det = (r.scode == STATUS_FLASH_ERR) ? FSTAT : UNUSED_CODE;
			adr = (r.scode == STATUS_FLASH_ERR) ? FADDR : UNUSED_CODE;
			e = '{8'h00, LEN_STATUS, r.rcode, r.scode, det[31:24], det[23:16], det[15:8],
				det[7:0], adr[31:24], adr[23:16], adr[15:8], adr[7:0]};
		end
		s = 8'h00;
		foreach (e[i])
			s -= e[i];
		e.push_back(s);
		e.push_back(TERMINATOR_BYTE);
		e.push_front(RESP_START_BYTE);
		@(posedge clk);
		lc <= r.lc;
		auth <= r.auth;
		ferr <= r.ferr;
		stall <= r.stall;
		lbac_host_i.resp.delete();
		fc0 = fcount;
		lbac_host_i.send(f);
		n = 0;
		while (n < 600 && lbac_host_i.resp.size() < e.size()) begin
			@(posedge clk);
			n++;
		end
		repeat (4) @(posedge clk);
		chk("response length", e.size(), lbac_host_i.resp.size());
		foreach (e[i])
			chk("response byte", e[i], lbac_host_i.resp[i]);
		fexp = fc0 + int'((r.scode == STATUS_OK || r.scode == STATUS_FLASH_ERR) &&
			r.cmd == CMD_ARC_SET);
		chk("flash writes", fexp, fcount);
		if (r.cmd == CMD_ARC_SET && r.scode == STATUS_OK)
			chk("stored config", {p[3], p[2], p[1], p[0]}, arc_cfg);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("ready after reset", 1'b1, rx_ready);
		chk("tx valid after reset", 1'b0, tx_valid);
		chk("flash request after reset", 1'b0, flash_req);
		chk("config after reset", 32'h0, arc_cfg);
		foreach (ROWS[i])
			run_row(ROWS[i], i);
		// Unknown code and empty frame are consumed without any answer
		@(posedge clk);
		stall <= 1'b0;
		lbac_host_i.resp.delete();
		lbac_host_i.send('{CMD_START_BYTE, 8'h00, 8'h01, 8'h4d, 8'hb2, TERMINATOR_BYTE});
		@(posedge clk);
		lbac_host_i.send('{CMD_START_BYTE, 8'h00, 8'h00, 8'h00, TERMINATOR_BYTE});
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk("answers to unknown code", 0, lbac_host_i.resp.size());
		chk("ready after unknown code", 1'b1, rx_ready);
		// Abort a configuration frame halfway by reset
		@(posedge clk);
		lbac_host_i.send('{CMD_START_BYTE, 8'h00, 8'h05, CMD_ARC_SET, 8'h11});
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("config after mid-run reset", 32'h0, arc_cfg);
		chk("ready after mid-run reset", 1'b1, rx_ready);
		chk("tx valid after mid-run reset", 1'b0, tx_valid);
		run_row(ROWS[0], 0);
		conclude();
	end
endmodule
`default_nettype wire

/* File: sim/lbac_host.sv */
`timescale 1ns/100ps
`default_nettype none
// Host tool model: sends command frames, collects response bytes
module lbac_host (
	// Clock
	input wire logic clk,
	// Command stream toward the device
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	// Response stream from the device
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// Sink pacing
	input wire logic stall
);
	logic [7:0] resp[$];

	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end

	// Stalling sink halves the drain rate
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			resp.push_back(tx_data);
		tx_ready <= stall ? ~tx_ready : 1'b1;
	end

	// Whole frame, held until taken; caller waits for the full answer first
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			rx_data <= q[i];
			rx_valid <= 1'b1;
			@(negedge clk);
			while (!rx_ready) @(negedge clk);
			@(posedge clk);
		end
		rx_valid <= 1'b0;
		// Released line shows no stale byte
		rx_data <= ~q[q.size()-1];
	endtask
endmodule
`default_nettype wire

/* File: verilog/lbac_cmd_handler.sv */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R01] In wait state, drop bytes until a command start byte arrives.
// [R02] Missing terminator byte gives packet error; command not executed.
// [R03] Checksum mismatch gives checksum error; command not executed.
// [R04] Length bytes wrong for format or for command give packet error.
// [R05] After any packet or acceptance error, no memory change, back to wait.
// [R06] Lifecycle state not permitting command gives acceptance error.
// [R07] Authentication level zero or one gives secure error, no execution.
// [R08] Report only top error: terminator, sum, format, length, lifecycle, auth, flash.
// [R09] Packet, sum, length, acceptance, secure errors fill details and address unused.
// [R10] Valid lock request sends lock data packet, memory untouched, then waits.
// [R11] Failed lock request answers 81h, 00h/0Ah, CBh, status, details, address.
// [R12] Root key hash lock bits are always sent as ones.
// [R13] Configuration write is 00h/05h, code 4Ch, four payload bytes, framed.
// [R14] First payload byte goes to lowest configuration address, rest ascending.
// [R15] After checks pass write flash; on failure report flash error, then wait.
// [R16] Flash error answer carries flash status and failing address.
// [R17] Write success answers 81h, 0Ah, 4Ch, status 00h, unused details and address.
// [R18] Write failure answers length 0Ah, code CCh, status, details, address.
// [R19] Host sends lock request 01h, 00h/01h, 4Bh, sum, terminator 03h.
// [R20] Lock data answer is 00h/13h, code 4Bh, 18 bytes lowest address first.
// [R21] In lock data, one means protection off, zero means protection on.
// [R22] Host waits for the whole answer before its next command.
// [R23] Packet checks run only after the whole declared frame has arrived.
module lbac_cmd_handler import lbac_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command byte stream
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	// Response byte stream
	output logic [7:0] tx_data_reg,
	output logic tx_valid_reg,
	input wire logic tx_ready,
	// Device security state
	input wire logic [3:0] lifecycle_state,
	input wire logic [1:0] auth_level,
	// Lock bit area, byte 0 at the lowest address
	input wire logic [8*LOCK_BYTES-1:0] lock_data,
	// Flash command interface
	output logic flash_wr_req_reg,
	output logic [8*ARC_BYTES-1:0] rollback_config_reg,
	input wire logic flash_wr_done,
	input wire logic flash_wr_error,
	input wire logic [31:0] flash_status,
	input wire logic [31:0] flash_fail_addr
);
	// ----------------------------------------
	// State and storage
	// ----------------------------------------
	lbac_state_t state_reg, state_next;
	logic [15:0] len_reg;
	logic [15:0] cnt_reg;
	logic [7:0] cmd_reg;
	logic etx_ok_reg;
	logic [7:0] resp_code_reg;
	logic [7:0] status_code_reg;
	logic [31:0] status_details_reg;
	logic [31:0] fail_addr_reg;
	logic lock_resp_reg;
	logic [4:0] tx_idx_reg;
	logic [7:0] rx_sum;
	logic [7:0] tx_sum;

	// Expand the tx index to a byte offset inside a 32-bit field, MSB first
	function automatic logic [7:0] field_byte(input logic [31:0] f, input logic [4:0] rel);
		logic [1:0] k;
		k = rel[1:0];
		field_byte = f[8*(3-k)+:8];
	endfunction

	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	logic rx_take;
	logic in_rx;
	logic soh_seen;
	logic body_last;
	logic rx_sum_clear;
	logic rx_sum_add;
	logic [15:0] len_word;
	logic [1:0] arc_lane;

	assign in_rx = (state_reg == ST_WAIT) || (state_reg == ST_LEN_H) ||
		(state_reg == ST_LEN_L) || (state_reg == ST_BODY) ||
		(state_reg == ST_SUM) || (state_reg == ST_ETX);
	assign rx_ready = in_rx;
	assign rx_take = rx_valid && in_rx;
	assign soh_seen = rx_take && (state_reg == ST_WAIT) && (rx_data == CMD_START_BYTE);
	assign body_last = (cnt_reg == 16'(len_reg - 16'h0001));
	assign len_word = {len_reg[15:8], rx_data};
	// Two-bit wrap keeps payload byte four in lane three, not off the end
	assign arc_lane = 2'(cnt_reg[1:0] - 2'h1);
	assign rx_sum_clear = soh_seen;
	assign rx_sum_add = rx_take && (state_reg != ST_WAIT) && (state_reg != ST_ETX);

	lbac_sum u_rx_sum (
		.clk(clk),
		.rst_n(rst_n),
		.clear(rx_sum_clear),
		.add_en(rx_sum_add),
		.add_byte(rx_data),
		.sum_reg(rx_sum)
	);

	// ----------------------------------------
	// Evaluation
	// ----------------------------------------
	logic is_lock;
	logic is_arc;
	logic err_etx;
	logic err_sum;
	logic err_fmt;
	logic err_len;
	logic err_lc;
	logic err_auth;
	logic any_err;
	logic [7:0] eval_status;
	logic [15:0] cmd_len;

	assign is_lock = (cmd_reg == CMD_LOCK_REQ);
	assign is_arc = (cmd_reg == CMD_ARC_SET);
	assign cmd_len = is_lock ? LEN_LOCK_CMD : LEN_ARC_CMD;
	assign err_etx = !etx_ok_reg;
	assign err_sum = (rx_sum != 8'h00); // see [R03]
	assign err_fmt = (len_reg < LEN_FMT_MIN) || (len_reg > LEN_FMT_MAX);
	assign err_len = (len_reg != cmd_len); // see [R04]
	assign err_lc = is_lock ? !LOCK_LC_MASK[lifecycle_state] : !ARC_LC_MASK[lifecycle_state];
	assign err_auth = (auth_level <= AUTH_LEVEL_ONE); // see [R07]
	assign any_err = err_etx || err_sum || err_fmt || err_len || err_lc || err_auth;
	// Priority chain, first match wins; see [R08] [R02] [R06]
	assign eval_status = err_etx ? STATUS_PACKET_ERR :
		err_sum ? STATUS_CHECKSUM_ERR :
		(err_fmt || err_len) ? STATUS_PACKET_ERR :
		err_lc ? STATUS_ACCEPT_ERR :
		err_auth ? STATUS_SECURE_ERR : STATUS_OK;

	// ----------------------------------------
	// Transmit side
	// ----------------------------------------
	logic tx_adv;
	logic [4:0] tx_last;
	logic [4:0] nidx;
	logic [4:0] lock_off;
	logic [7:0] lock_byte;
	logic [7:0] status_byte;
	logic [7:0] body_byte;
	logic [7:0] nbyte;
	logic send_start;
	logic tx_sum_add;

	assign tx_last = lock_resp_reg ? LAST_LOCK : LAST_STATUS;
	assign tx_adv = tx_valid_reg && tx_ready;
	assign nidx = 5'(tx_idx_reg + 5'h01);
	assign lock_off = 5'(nidx - POS_PAYLOAD);
	// Lowest address first, hash lock bits forced to ones; see [R20] [R12] [R21]
	assign lock_byte = lock_data[8*lock_off+:8] |
		((nidx == HASH_LOCK_POS) ? HASH_LOCK_MASK : 8'h00);
	assign status_byte = (nidx == POS_STATUS) ? status_code_reg :
		(nidx < POS_ADDR) ? field_byte(status_details_reg, 5'(nidx - POS_DETAIL)) :
		field_byte(fail_addr_reg, 5'(nidx - POS_ADDR));
	assign body_byte = lock_resp_reg ? lock_byte : status_byte;
	assign nbyte = (nidx == POS_LEN_HIGH) ? LENGTH_HIGH_FIXED :
		(nidx == POS_LEN_LOW) ? (lock_resp_reg ? LEN_LOCK_DATA : LEN_STATUS) :
		(nidx == POS_RESP_CODE) ? resp_code_reg :
		(nidx == tx_last) ? TERMINATOR_BYTE :
		(nidx == 5'(tx_last - 5'h01)) ? 8'(8'h00 - tx_sum) : body_byte;
	assign send_start = (state_reg != ST_SEND) && (state_next == ST_SEND);
	assign tx_sum_add = tx_adv && (nidx < 5'(tx_last - 5'h01));

	lbac_sum u_tx_sum (
		.clk(clk),
		.rst_n(rst_n),
		.clear(send_start),
		.add_en(tx_sum_add),
		.add_byte(nbyte),
		.sum_reg(tx_sum)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_WAIT: if (soh_seen) state_next = ST_LEN_H; // see [R01]
			ST_LEN_H: if (rx_take) state_next = ST_LEN_L;
			ST_LEN_L: if (rx_take) state_next = (len_word == 16'h0000) ? ST_SUM : ST_BODY;
			ST_BODY: if (rx_take && body_last) state_next = ST_SUM; // see [R23]
			ST_SUM: if (rx_take) state_next = ST_ETX;
			ST_ETX: if (rx_take) state_next = ST_EVAL;
			ST_EVAL: begin
				// Codes for other handlers are left alone
				if (!is_lock && !is_arc) state_next = ST_WAIT;
				else if (any_err || is_lock) state_next = ST_SEND; // see [R05] [R10]
				else state_next = ST_FLASH; // see [R15]
			end
			ST_FLASH: if (flash_wr_done) state_next = ST_SEND;
			ST_SEND: if (tx_adv && tx_idx_reg == tx_last) state_next = ST_WAIT;
			default: state_next = ST_WAIT;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_WAIT;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Frame capture
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			len_reg <= 16'h0000;
			cnt_reg <= 16'h0000;
			cmd_reg <= 8'h00;
			etx_ok_reg <= 1'b0;
			rollback_config_reg <= '0;
		end else if (soh_seen) begin
			cmd_reg <= 8'h00;
			etx_ok_reg <= 1'b0;
			cnt_reg <= 16'h0000;
		end else if (rx_take) begin
			case (state_reg)
				ST_LEN_H: len_reg <= {rx_data, 8'h00};
				ST_LEN_L: len_reg <= len_word;
				ST_BODY: begin
					cnt_reg <= 16'(cnt_reg + 16'h0001);
					if (cnt_reg == 16'h0000) cmd_reg <= rx_data;
					// Payload byte n lands in lane n-1, first byte lowest; see [R14] [R13]
					else if (cnt_reg <= 16'(ARC_BYTES))
						rollback_config_reg[8*arc_lane+:8] <= rx_data;
				end
				ST_ETX: etx_ok_reg <= (rx_data == TERMINATOR_BYTE); // see [R02]
				default: cnt_reg <= cnt_reg;
			endcase
		end
	end

	// ----------------------------------------
	// Response fields
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			resp_code_reg <= 8'h00;
			status_code_reg <= STATUS_OK;
			status_details_reg <= UNUSED_CODE;
			fail_addr_reg <= UNUSED_CODE;
			lock_resp_reg <= 1'b0;
		end else if (state_reg == ST_EVAL) begin
			lock_resp_reg <= is_lock && !any_err;
			status_code_reg <= eval_status;
			status_details_reg <= UNUSED_CODE; // see [R09]
			fail_addr_reg <= UNUSED_CODE;
			// see [R11] [R18] [R10]
			resp_code_reg <= is_lock ? (any_err ? RESP_LOCK_ERR : RESP_LOCK_DATA) :
				RESP_ARC_ERR;
		end else if (state_reg == ST_FLASH && flash_wr_done) begin
			if (flash_wr_error) begin
				status_code_reg <= STATUS_FLASH_ERR; // see [R15]
				status_details_reg <= flash_status; // see [R16]
				fail_addr_reg <= flash_fail_addr;
				resp_code_reg <= RESP_ARC_ERR; // see [R18]
			end else begin
				status_code_reg <= STATUS_OK; // see [R17]
				resp_code_reg <= RESP_ARC_OK;
			end
		end
	end

	// ----------------------------------------
	// Flash request and byte output
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flash_wr_req_reg <= 1'b0;
		end else begin
			flash_wr_req_reg <= (state_reg == ST_EVAL) && (state_next == ST_FLASH);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
			tx_idx_reg <= 5'h00;
		end else if (send_start) begin
			tx_valid_reg <= 1'b1;
			tx_data_reg <= RESP_START_BYTE;
			tx_idx_reg <= 5'h00;
		end else if (tx_adv) begin
			tx_valid_reg <= (tx_idx_reg != tx_last);
			tx_data_reg <= nbyte;
			tx_idx_reg <= nidx;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	noise_drop_a: assert property ( // see [R01]
		(state_reg == ST_WAIT && rx_valid && rx_data != CMD_START_BYTE) |=> state_reg == ST_WAIT)
		else $error("non-start byte left wait state");

	no_bad_write_a: assert property ( // see [R05]
		flash_wr_req_reg |-> $past(state_reg) == ST_EVAL && !$past(any_err) && $past(is_arc))
		else $error("flash write after failed checks");

	etx_first_a: assert property ( // see [R02]
		(state_reg == ST_EVAL && (is_lock || is_arc) && err_etx) |=>
		status_code_reg == STATUS_PACKET_ERR && state_reg == ST_SEND)
		else $error("terminator error not reported first");

	sum_err_a: assert property ( // see [R03]
		(state_reg == ST_EVAL && (is_lock || is_arc) && !err_etx && err_sum) |=>
		status_code_reg == STATUS_CHECKSUM_ERR)
		else $error("checksum error not reported");

	secure_err_a: assert property ( // see [R07]
		(state_reg == ST_EVAL && is_arc && !err_etx && !err_sum && !err_fmt && !err_len &&
		!err_lc && err_auth) |=> status_code_reg == STATUS_SECURE_ERR && !flash_wr_req_reg)
		else $error("secure error missed");

	unused_fill_a: assert property ( // see [R09]
		(state_reg == ST_SEND && status_code_reg != STATUS_FLASH_ERR) |->
		status_details_reg == UNUSED_CODE && fail_addr_reg == UNUSED_CODE)
		else $error("details not unused code");

	hash_mask_a: assert property ( // see [R12]
		(tx_valid_reg && lock_resp_reg && tx_idx_reg == HASH_LOCK_POS) |->
		tx_data_reg[7:6] == 2'b11)
		else $error("hash lock bits not all ones");

	flash_fail_a: assert property ( // see [R16]
		(state_reg == ST_FLASH && flash_wr_done && flash_wr_error) |=>
		status_details_reg == $past(flash_status) && fail_addr_reg == $past(flash_fail_addr) &&
		resp_code_reg == RESP_ARC_ERR)
		else $error("flash failure fields wrong");

	resp_head_a: assert property ( // see [R11] [R17] [R20]
		send_start |=> tx_valid_reg && tx_data_reg == RESP_START_BYTE)
		else $error("response start byte wrong");

	len_high_a: assert property ( // see [R11] [R17] [R20]
		(tx_adv && tx_idx_reg == 5'h00) |=> tx_valid_reg && tx_data_reg == LENGTH_HIGH_FIXED)
		else $error("response length high byte wrong");
endmodule
`default_nettype wire

/* File: verilog/lbac_pkg.sv */
`default_nettype none
package lbac_pkg;
	// ----------------------------------------
	// Framing bytes and codes
	// ----------------------------------------
	localparam logic [7:0] CMD_START_BYTE = 8'h01;
	localparam logic [7:0] RESP_START_BYTE = 8'h81;
	localparam logic [7:0] TERMINATOR_BYTE = 8'h03;
	localparam logic [7:0] LENGTH_HIGH_FIXED = 8'h00;
	localparam logic [7:0] CMD_LOCK_REQ = 8'h4b;
	localparam logic [7:0] CMD_ARC_SET = 8'h4c;
	localparam logic [7:0] RESP_LOCK_DATA = 8'h4b;
	localparam logic [7:0] RESP_LOCK_ERR = 8'hcb;
	localparam logic [7:0] RESP_ARC_OK = 8'h4c;
	localparam logic [7:0] RESP_ARC_ERR = 8'hcc;

	// ----------------------------------------
	// Lengths
	// ----------------------------------------
	localparam logic [15:0] LEN_LOCK_CMD = 16'h0001;
	localparam logic [15:0] LEN_ARC_CMD = 16'h0005;
	localparam logic [15:0] LEN_FMT_MIN = 16'h0001;
	localparam logic [15:0] LEN_FMT_MAX = 16'h0401;
	localparam logic [7:0] LEN_LOCK_DATA = 8'h13;
	localparam logic [7:0] LEN_STATUS = 8'h0a;
	localparam int LOCK_BYTES = 18;
	localparam int ARC_BYTES = 4;

	// ----------------------------------------
	// Response byte positions
	// ----------------------------------------
	localparam logic [4:0] POS_LEN_HIGH = 5'h01;
	localparam logic [4:0] POS_LEN_LOW = 5'h02;
	localparam logic [4:0] POS_RESP_CODE = 5'h03;
	localparam logic [4:0] POS_STATUS = 5'h04;
	localparam logic [4:0] POS_DETAIL = 5'h05;
	localparam logic [4:0] POS_ADDR = 5'h09;
	localparam logic [4:0] POS_PAYLOAD = 5'h04;
	localparam logic [4:0] LAST_LOCK = 5'h17;
	localparam logic [4:0] LAST_STATUS = 5'h0e;
	localparam logic [4:0] HASH_LOCK_POS = 5'h15;
	localparam logic [7:0] HASH_LOCK_MASK = 8'hc0;

	// ----------------------------------------
	// Status codes and field values
	// ----------------------------------------
	localparam logic [7:0] STATUS_OK = 8'h00;
	localparam logic [7:0] STATUS_PACKET_ERR = 8'hc1;
	localparam logic [7:0] STATUS_CHECKSUM_ERR = 8'hc2;
	localparam logic [7:0] STATUS_ACCEPT_ERR = 8'hc3;
	localparam logic [7:0] STATUS_SECURE_ERR = 8'hc4;
	localparam logic [7:0] STATUS_FLASH_ERR = 8'hc5;
	localparam logic [31:0] UNUSED_CODE = 32'hffffffff;

	// ----------------------------------------
	// Acceptance
	// ----------------------------------------
	localparam logic [1:0] AUTH_LEVEL_ONE = 2'h1;
	localparam logic [15:0] LOCK_LC_MASK = 16'hfffe;
	localparam logic [15:0] ARC_LC_MASK = 16'hfffe;

	typedef enum logic [3:0] {
		ST_WAIT = 4'b0000,
		ST_LEN_H = 4'b0001,
		ST_LEN_L = 4'b0010,
		ST_BODY = 4'b0011,
		ST_SUM = 4'b0100,
		ST_ETX = 4'b0101,
		ST_EVAL = 4'b0110,
		ST_FLASH = 4'b0111,
		ST_SEND = 4'b1000
	} lbac_state_t;
endpackage
`default_nettype wire

/* File: verilog/lbac_sum.sv */
`timescale 1ns/100ps
`default_nettype none
// Running byte sum; a frame is good when its bytes plus the sum byte give zero
module lbac_sum import lbac_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic clear,
	input wire logic add_en,
	input wire logic [7:0] add_byte,
	// Result
	output logic [7:0] sum_reg
);
	logic [7:0] sum_next;

	assign sum_next = clear ? 8'h00 : (add_en ? 8'(sum_reg + add_byte) : sum_reg);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sum_reg <= 8'h00;
		end else begin
			sum_reg <= sum_next;
		end
	end
endmodule
`default_nettype wire
